// ==== pkg/twc_pkg.sv ====
// Constants, register map and state types of the three-wire port controller.
package twc_pkg;
   // Clock rate and the fastest serial clock the device accepts.
   localparam int unsigned CLK_HZ = 100_000_000;
   localparam int unsigned SCLK_MAX_HZ = 2_000_000;
   // Half period rounded up, so the serial clock at the reset divider never exceeds its limit.
   localparam int unsigned HALF_CYC =
      (CLK_HZ + 2 * SCLK_MAX_HZ - 1) / (2 * SCLK_MAX_HZ);
   localparam logic [15:0] DIV_RESET = 16'(HALF_CYC);
   localparam logic [15:0] DIV_MIN = 16'h0004;

   // Own register byte offsets.
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_WDATA = 8'h04;
   localparam logic [7:0] OFS_RDATA = 8'h08;
   localparam logic [7:0] OFS_STATUS = 8'h0C;
   localparam logic [7:0] OFS_DIV = 8'h10;

   // Command register fields.
   localparam int CTRL_OP_LO = 0;
   localparam int CTRL_ADDR_LO = 4;
   localparam int CTRL_LEN_LO = 8;
   // Status register fields.
   localparam int ST_BUSY = 0;
   localparam int ST_MODEM = 1;
   localparam int ST_DONE = 2;
   localparam int ST_ERR = 3;

   // Commands.
   localparam logic [1:0] OP_WRITE = 2'h0;
   localparam logic [1:0] OP_READ = 2'h1;
   localparam logic [1:0] OP_MODEM_ON = 2'h2;
   localparam logic [1:0] OP_MODEM_OFF = 2'h3;

   // Device register map.
   localparam logic [3:0] DEV_ADDR_MIN = 4'h1;
   localparam logic [3:0] DEV_ADDR_MAX = 4'hA;
   localparam logic [3:0] DEV_PWR_STATUS = 4'h5;
   localparam logic [3:0] DEV_READBACK = 4'hA;
   localparam logic [3:0] DEV_MODEM_ADDR = 4'hB;
   localparam int DEV_WIDTH = 24;
   localparam int MODEM_BIT = 20;
   localparam int HDR_BITS = 5;
   localparam logic [4:0] WR_LEN_MIN = 5'h04;
   localparam logic [4:0] RD_LEN_MIN = 5'h01;
   localparam logic [4:0] LEN_MAX = 5'h18;
   localparam logic HDR_WRITE = 1'b0;
   localparam logic HDR_READ = 1'b1;

   // Sequencer states, one-hot.
   typedef enum logic [8:0] {
      S_IDLE = 9'h001,
      S_LEAD = 9'h002,
      S_HDR = 9'h004,
      S_GAP = 9'h008,
      S_DATA = 9'h010,
      S_TAIL = 9'h020,
      S_PH = 9'h040,
      S_PL = 9'h080,
      S_MODEM = 9'h100
   } twc_state_t;

   // Pins toward the device.
   typedef struct packed {
      logic sclk;
      logic en;
      logic data_o;
      logic data_oe;
   } twc_pins_t;

   // Whole module state.
   typedef struct packed {
      twc_state_t st;
      logic [15:0] cnt;
      logic ph;
      logic [4:0] bits;
      logic [23:0] sh;
      logic [1:0] op;
      logic [3:0] addr;
      logic [4:0] len;
      logic [23:0] wdata;
      logic [23:0] rdata;
      logic [15:0] div;
      logic modem;
      logic modem_bit;
      logic done;
      logic err;
      twc_pins_t pins;
      logic din_s1;
      logic din_s2;
      logic [31:0] prdata;
      logic pslverr;
   } twc_reg_t;
endpackage

// ==== verilog/twc_host.sv ====
// Host controller that drives the three-wire control port from APB commands.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// RULE1: Device port never powers down; host may talk to it anytime.
// RULE2: Serial clock at most 2.0 MHz, stopped and enable low when idle; the divider accepts writes down to 4, which gives 12.5 MHz.
// RULE3: Ten 24-bit device registers, addresses 1 to 10.
// RULE4: Register 10 and bits 23-21 of register 5 are read-only status.
// RULE5: Every serial bit moves on the serial clock rising edge.
// RULE6: Write header: enable high, bit 0, then address MSB first.
// RULE7: Enable drops after fifth header clock is low; address latched.
// RULE8: Write data MSB first with enable low, zeros in unused bits.
// RULE9: Enable pulse with clock steady commits the written data.
// RULE10: Writes carry 4 to 24 low-order bits.
// RULE11: Read header: enable high, bit 1, then address MSB first.
// RULE12: Device loads output shifter at enable fall, data pin stays input.
// RULE13: First read rising edge drives bit 23; 1 to 24 edges allowed.
// RULE14: Host samples read bits on serial clock falling edge.
// RULE15: Enable pulse after a read returns the data pin to input.
// RULE16: Modem bit set plus address 11 makes device drive recovered clock.
// RULE17: Host sets modem bit, sends address 11, releases data first.
// RULE18: While recovered clock runs, no control transfers are made.
// RULE19: Enable pulse exits modem mode; then modem bit gets cleared.
// RULE20: Modem bit stays cleared whenever modem mode is unused.
// RULE21: Register 5 bits 0-10 disable their sections when set.
// RULE22: Reference divider stops only when register 5 bits 1-3 all set.
// RULE23: Disabled battery_carrier_detector reads high in status bit 23.
module twc_host
   import twc_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Serial port toward the device
   output logic sclk,
   output logic en,
   output logic data_o,
   output logic data_oe,
   input wire logic data_i
);

   twc_reg_t q, d;
   logic setup;
   logic wr_acc;
   logic tick;
   logic [3:0] a;
   logic [4:0] n;
   logic [1:0] op;
   logic start_ok;

   // Sequencer outline. A command written to the control register leaves
   // idle for the lead stage, which raises enable and puts the header flag
   // on the data pin. The header stage then clocks five bits, and the data
   // stage the number of bits that the command asked for. Every serial bit
   // takes two half periods: the clock is low while the data pin settles,
   // and high after the rising edge at which the device takes the bit.
   // The gap stage waits one half period with the clock low before enable
   // falls, so the device never sees enable move near a clock edge. The
   // tail stage does the same before the closing enable pulse, which lasts
   // one half period high and one half period low.
   // Read bits come back through the two-flop synchroniser. They are taken
   // at the falling edge of the serial clock, a full half period after the
   // device moved them, which is why the divider may not go below four.
   // In modem mode the pins stand still and only an exit command is taken.
   // The exit first waits one low half period, so that its pulse is as
   // wide as any other closing pulse.
   // Busy covers the whole of a transfer but not the modem state, so that
   // software can poll it after entering modem mode and then issue the exit.
   // The copy of the modem bit follows the last completed write to the
   // power-down and status register that was long enough to reach that bit.
   // A refused command sets the error flag and leaves every pin as it was.
   // It never changes the stored command fields either.

   // Slave answers in the first access cycle; data was prepared at setup.
   assign pready = 1'b1;
   assign prdata = q.prdata;
   assign pslverr = q.pslverr;
   assign sclk = q.pins.sclk;
   assign en = q.pins.en;
   assign data_o = q.sh[DEV_WIDTH-1];
   assign data_oe = q.pins.data_oe;

   assign setup = psel & ~penable;
   assign wr_acc = psel & penable & pwrite;
   assign tick = (q.cnt == 16'h0000);
   assign op = pwdata[CTRL_OP_LO +: 2];
   assign a = pwdata[CTRL_ADDR_LO +: 4];
   assign n = pwdata[CTRL_LEN_LO +: 5];

   // Command check; write and read need a legal address and length.
   always_comb begin
      start_ok = 1'b0;
      // RULE3: address range
      if (op == OP_WRITE) begin
         // RULE10: write length
         start_ok = (q.st == S_IDLE) && (a >= DEV_ADDR_MIN) &&
            (a <= DEV_ADDR_MAX) && (n >= WR_LEN_MIN) && (n <= LEN_MAX);
      end else if (op == OP_READ) begin
         // RULE13: read length
         start_ok = (q.st == S_IDLE) && (a >= DEV_ADDR_MIN) &&
            (a <= DEV_ADDR_MAX) && (n >= RD_LEN_MIN) && (n <= LEN_MAX);
      end else if (op == OP_MODEM_ON) begin
         // RULE16: modem entry only with modem bit written
         start_ok = (q.st == S_IDLE) && q.modem_bit;
      end else begin
         // RULE19: exit only from modem mode
         start_ok = (q.st == S_MODEM);
      end
   end

   // All state is computed here and registered below.
   always_comb begin
      d = q;
      // Two-stage synchroniser for the data pin.
      d.din_s1 = data_i;
      d.din_s2 = q.din_s1;

      // Divider: one tick per half period of the serial clock.
      // RULE2: clock rate bounded by the divider
      if (q.st == S_IDLE || q.st == S_MODEM || tick) begin
         d.cnt = q.div - 16'h0001;
      end else begin
         d.cnt = q.cnt - 16'h0001;
      end

      // APB read data and error are prepared in the setup cycle.
      if (setup) begin
         d.pslverr = 1'b0;
         d.prdata = 32'h0000_0000;
         if (paddr == OFS_CTRL) begin
            d.prdata = {19'h0, q.len, q.addr, 2'h0, q.op};
         end else if (paddr == OFS_WDATA) begin
            d.prdata = {8'h00, q.wdata};
         end else if (paddr == OFS_RDATA) begin
            d.prdata = {8'h00, q.rdata};
         end else if (paddr == OFS_STATUS) begin
            d.prdata = {28'h0, q.err, q.done, q.modem,
               (q.st != S_IDLE) && (q.st != S_MODEM)};
         end else if (paddr == OFS_DIV) begin
            d.prdata = {16'h0000, q.div};
         end else begin
            d.pslverr = 1'b1;
         end
      end

      // Register writes; the done and error flags clear by writing ones.
      if (wr_acc) begin
         if (paddr == OFS_WDATA) begin
            d.wdata = pwdata[DEV_WIDTH-1:0];
         end else if (paddr == OFS_DIV) begin
            // A floor keeps the synchroniser delay inside a half period.
            d.div = (pwdata[15:0] < DIV_MIN) ? DIV_MIN : pwdata[15:0];
         end else if (paddr == OFS_STATUS) begin
            if (pwdata[ST_DONE]) begin
               d.done = 1'b0;
            end
            if (pwdata[ST_ERR]) begin
               d.err = 1'b0;
            end
         end else if (paddr == OFS_CTRL) begin
            if (!start_ok) begin
               d.err = 1'b1;
            end else if (op == OP_MODEM_OFF) begin
               // A low stretch first gives the exit pulse its full width.
               d.op = op;
               d.st = S_TAIL;
            end else begin
               d.op = op;
               d.addr = (op == OP_MODEM_ON) ? DEV_MODEM_ADDR : a;
               d.len = n;
               d.st = S_LEAD;
            end
         end
      end

      // Serial sequencer.
      case (q.st)
         S_IDLE: begin
            d.pins.sclk = 1'b0;
            d.pins.en = 1'b0;
            d.ph = 1'b0;
         end
         S_LEAD: begin
            // RULE6: enable high, write flag and address
            // RULE11: read flag for reads
            d.pins.en = 1'b1;
            d.pins.data_oe = 1'b1;
            d.sh = {(q.op == OP_READ) ? HDR_READ : HDR_WRITE, q.addr,
               19'h00000};
            d.bits = 5'(HDR_BITS);
            if (tick) begin
               d.st = S_HDR;
            end
         end
         S_HDR, S_DATA: begin
            if (tick) begin
               if (!q.ph) begin
                  // RULE5: bit moves on this rising edge
                  d.pins.sclk = 1'b1;
                  d.ph = 1'b1;
               end else begin
                  d.pins.sclk = 1'b0;
                  d.ph = 1'b0;
                  d.bits = q.bits - 5'h01;
                  // RULE14: read bit taken at the falling edge
                  d.sh = {q.sh[DEV_WIDTH-2:0], q.din_s2};
                  if (q.bits == 5'h01) begin
                     d.st = (q.st == S_HDR) ? S_GAP : S_TAIL;
                  end
               end
            end
         end
         S_GAP: begin
            // RULE17: data released before enable falls on modem entry
            if (q.op == OP_MODEM_ON) begin
               d.pins.data_oe = 1'b0;
            end
            if (tick) begin
               // RULE7: enable falls after the fifth clock is low
               d.pins.en = 1'b0;
               d.bits = q.len;
               if (q.op == OP_WRITE) begin
                  // RULE8: MSB first, only low-order bits sent
                  d.sh = q.wdata << (5'(DEV_WIDTH) - q.len);
                  d.st = S_DATA;
               end else if (q.op == OP_READ) begin
                  // RULE12: host stops driving as the shifter loads
                  d.pins.data_oe = 1'b0;
                  d.st = S_DATA;
               end else begin
                  // RULE18: port held quiet while recovered clock runs
                  d.modem = 1'b1;
                  d.st = S_MODEM;
               end
            end
         end
         S_TAIL: begin
            if (tick) begin
               if (q.op == OP_READ) begin
                  d.rdata = q.sh;
               end
               d.pins.en = 1'b1;
               d.st = S_PH;
            end
         end
         S_PH: begin
            // RULE9: enable pulse with the clock held low
            // RULE15: same pulse ends a read
            d.pins.en = 1'b1;
            if (tick) begin
               d.pins.en = 1'b0;
               d.st = S_PL;
            end
         end
         S_PL: begin
            if (tick) begin
               d.pins.data_oe = 1'b0;
               d.st = S_IDLE;
               // Done is set here; set wins over a same-cycle clear.
               d.done = 1'b1;
               if (q.op == OP_MODEM_OFF) begin
                  // RULE19: modem mode was left at the enable fall one half period earlier
                  d.modem = 1'b0;
               end
               // RULE20: track the modem bit written to register 5
               if (q.op == OP_WRITE && q.addr == DEV_PWR_STATUS &&
                  q.len > 5'(MODEM_BIT)) begin
                  d.modem_bit = q.wdata[MODEM_BIT];
               end
            end
         end
         S_MODEM: begin
            d.pins.sclk = 1'b0;
            d.pins.en = 1'b0;
         end
         default: begin
            d.st = S_IDLE;
         end
      endcase
   end

   // State register; reset gives idle pins and the default divider.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '0;
         q.st <= S_IDLE;
         q.div <= DIV_RESET;
      end else begin
         q <= d;
      end
   end

endmodule
`default_nettype wire

// ==== verif/twc_host_props.sv ====
// Pin-level checks on the three-wire port controller.
`timescale 1ns/1ps
`default_nettype none
module twc_host_props
   import twc_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic [7:0] paddr,
   input wire logic pready,
   input wire logic pslverr,
   // Serial pins
   input wire logic sclk,
   input wire logic en,
   input wire logic data_o,
   input wire logic data_oe
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   int hc;
   int dc;
   // Count clock rises per enable phase; an enable edge starts afresh.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hc <= 0;
         dc <= 0;
      end else begin
         hc <= $changed(en) ? 0 : hc + int'($rose(sclk) && en);
         dc <= $changed(en) ? 0 : dc + int'($rose(sclk) && !en);
      end
   end
   property p_sclk_hi; $rose(sclk) |=> $stable(sclk) [*3]; endproperty
   a_sclk_hi: assert property (p_sclk_hi) else $error("sclk high short");
   property p_sclk_lo; $fell(sclk) |=> $stable(sclk) [*3]; endproperty
   a_sclk_lo: assert property (p_sclk_lo) else $error("sclk low short");
   property p_en_edge; $changed(en) |-> !sclk; endproperty
   a_en_edge: assert property (p_en_edge) else $error("en moved, sclk hi");
   property p_dat; $rose(sclk) |-> $stable(data_o) && $stable(data_oe); endproperty
   a_dat: assert property (p_dat) else $error("data moved at rise");
   property p_hdr; en && $rose(sclk) |-> data_oe && hc < 5; endproperty
   a_hdr: assert property (p_hdr) else $error("bad header bit");
   property p_hdr_n; $fell(en) |-> hc == 0 || hc == 5; endproperty
   a_hdr_n: assert property (p_hdr_n) else $error("header count");
   property p_dat_n; $rose(en) |-> dc <= 24; endproperty
   a_dat_n: assert property (p_dat_n) else $error("too many bits");
   property p_pulse; $rose(en) |=> en [*3]; endproperty
   a_pulse: assert property (p_pulse) else $error("enable pulse short");
   property p_slv; psel && penable && paddr > OFS_DIV |-> pslverr && pready;
   endproperty
   a_slv: assert property (p_slv) else $error("no slave error");
endmodule
`default_nettype wire

// ==== verif/twc_dev_model.sv ====
// Behavioural model of the device end of the three-wire port.
`timescale 1ns/1ps
`default_nettype none
module twc_dev_model
   import twc_pkg::*;
#(
   // Arbitrary patterns for the read-only places.
   parameter logic [2:0] ST5 = 3'h2,
   parameter logic [23:0] RB10 = 24'h3C5A69
)(
   // Pins from the host
   input wire logic sclk,
   input wire logic en,
   input wire logic data_o,
   input wire logic data_oe,
   // Resolved data pin
   output logic dio
);
   logic [23:0] regs [1:10];
   logic [23:0] sh, m;
   logic [4:0] hdr, k;
   logic [3:0] a;
   logic dat = 0, rd = 0, modem = 0, doe = 0, dq = 0, rclk = 0, seen = 0;
   // The settle of enable at start-up is not a falling edge of a transfer.
   always @(posedge en) seen = 1'b1;
   initial for (int i = 1; i <= 10; i++) regs[i] = 24'h0;
   always #40 rclk = ~rclk;
   // A released pin shows the inverse of the last bit, not a stale copy.
   assign dio = data_oe ? data_o : modem ? rclk : doe ? dq : ~dq;
   function automatic logic [23:0] rv(input logic [3:0] x);
      if (x == 4'h5) return {regs[5][10] | ST5[2], ST5[1:0], regs[5][20:0]};
      if (x == 4'hA) return RB10;
      return (x >= 4'h1 && x <= 4'h9) ? regs[x] : 24'h0;
   endfunction
   always @(posedge sclk) begin
      if (modem) begin
      end else if (en) begin
         hdr <= {hdr[3:0], dio};
      end else if (dat && rd) begin
         doe <= 1'b1;
         dq <= sh[23];
         sh <= sh << 1;
      end else if (dat) begin
         sh <= {sh[22:0], dio};
         k <= k + 5'h1;
      end
   end
   always @(negedge en) begin
      m = (24'h1 << k) - 24'h1;
      if (a == 4'h5) m = m & 24'h1FFFFF;
      if (!seen) begin
      end else if (modem) begin
         modem <= 1'b0;
      end else if (dat) begin
         if (!rd && k >= 5'h4 && a >= 4'h1 && a <= 4'h9)
            regs[a] <= (regs[a] & ~m) | (sh & m);
         dat <= 1'b0;
         doe <= 1'b0;
      end else if (hdr[3:0] == DEV_MODEM_ADDR) begin
         modem <= regs[5][MODEM_BIT];
      end else begin
         a <= hdr[3:0];
         rd <= hdr[4];
         dat <= 1'b1;
         k <= 5'h0;
         sh <= rv(hdr[3:0]);
      end
   end
endmodule
`default_nettype wire

// ==== verif/twc_host_tb.sv ====
// Self-checking bench for the three-wire port controller.
`timescale 1ns/1ps
`default_nettype none
module twc_host_tb
   import twc_pkg::*;
();
   localparam logic [23:0] RB = 24'h3C5A69;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, perr;
   logic sclk, en, data_o, data_oe, dio;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, r;
   int failures = 0, cmp_count = 0, cyc = 0;
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin failures++; \
$display("ERROR %0t got %h exp %h", $time, g, e); end end
   twc_host dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .sclk(sclk),
      .en(en), .data_o(data_o), .data_oe(data_oe), .data_i(dio));
   twc_dev_model #(.ST5(3'h2), .RB10(RB)) dm (.sclk(sclk), .en(en),
      .data_o(data_o), .data_oe(data_oe), .dio(dio));
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   // One transfer; the request holds until pready is seen high.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      perr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Start a serial command, wait while busy, then check and clear err.
   task automatic cmd(input logic [1:0] op, input logic [3:0] a,
         input logic [4:0] n, input logic e);
      apb(1'b1, OFS_CTRL, {19'h0, n, a, 2'h0, op});
      do apb(1'b0, OFS_STATUS, 32'h0); while (r[ST_BUSY] !== 1'b0);
      `CHK(r[ST_ERR], e)
      apb(1'b1, OFS_STATUS, 32'hC);
   endtask
   task automatic rdv(input logic [3:0] a, input logic [4:0] n);
      cmd(OP_READ, a, n, 1'b0);
      apb(1'b0, OFS_RDATA, 32'h0);
   endtask
   task automatic t_regs;
      apb(1'b0, OFS_DIV, 32'h0);
      `CHK(r[15:0], DIV_RESET)
      apb(1'b1, OFS_DIV, 32'h2);
      apb(1'b0, OFS_DIV, 32'h0);
      `CHK(r[15:0], DIV_MIN)
      apb(1'b0, 8'h14, 32'h0);
      `CHK(perr, 1'b1)
      $display("regs test done");
   endtask
   // Full write, short write of low bits, then read back whole.
   task automatic t_wr;
      apb(1'b1, OFS_WDATA, 32'h00A5C396);
      cmd(OP_WRITE, 4'h3, LEN_MAX, 1'b0);
      `CHK(dm.regs[3], 24'hA5C396)
      apb(1'b1, OFS_WDATA, 32'h0000000B);
      cmd(OP_WRITE, 4'h3, WR_LEN_MIN, 1'b0);
      rdv(4'h3, LEN_MAX);
      `CHK(r[23:0], 24'hA5C39B)
      apb(1'b1, OFS_WDATA, 32'h00FFFFFF);
      cmd(OP_WRITE, DEV_READBACK, LEN_MAX, 1'b0);
      rdv(DEV_READBACK, LEN_MAX);
      `CHK(r[23:0], RB)
      $display("write test done");
   endtask
   // Short status reads with the detector off and on.
   task automatic t_stat;
      apb(1'b1, OFS_WDATA, 32'h000007FF);
      cmd(OP_WRITE, DEV_PWR_STATUS, 5'h0B, 1'b0);
      rdv(DEV_PWR_STATUS, 5'h3);
      `CHK(r[2:0], 3'h6)
      apb(1'b1, OFS_WDATA, 32'h0);
      cmd(OP_WRITE, DEV_PWR_STATUS, 5'h0B, 1'b0);
      rdv(DEV_PWR_STATUS, RD_LEN_MIN);
      `CHK(r[0], 1'b0)
      $display("status test done");
   endtask
   task automatic t_bad;
      cmd(OP_WRITE, 4'h3, 5'h3, 1'b1);
      cmd(OP_READ, 4'h0, LEN_MAX, 1'b1);
      cmd(OP_READ, 4'hB, RD_LEN_MIN, 1'b1);
      cmd(OP_MODEM_ON, DEV_MODEM_ADDR, 5'h0, 1'b1);
      cmd(OP_MODEM_OFF, 4'h0, 5'h0, 1'b1);
      $display("refusal test done");
   endtask
   task automatic t_modem;
      apb(1'b1, OFS_WDATA, 32'h00100000);
      cmd(OP_WRITE, DEV_PWR_STATUS, 5'h15, 1'b0);
      cmd(OP_MODEM_ON, DEV_MODEM_ADDR, 5'h0, 1'b0);
      apb(1'b0, OFS_STATUS, 32'h0);
      `CHK({r[ST_MODEM], dm.modem}, 2'h3)
      cmd(OP_WRITE, 4'h3, LEN_MAX, 1'b1);
      `CHK(dm.regs[3], 24'hA5C39B)
      cmd(OP_MODEM_OFF, 4'h0, 5'h0, 1'b0);
      `CHK(dm.modem, 1'b0)
      apb(1'b1, OFS_WDATA, 32'h0);
      cmd(OP_WRITE, DEV_PWR_STATUS, 5'h15, 1'b0);
      `CHK(dm.regs[5], 24'h0)
      $display("modem test done");
   endtask
   task automatic report_and_stop;
      $display("failures=%0d compares=%0d", failures, cmp_count);
      if (failures == 0 && cmp_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // A hang is cut short well beyond the expected run length.
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 60000) begin
         failures++;
         report_and_stop;
      end
   end
   initial begin
      {presetn, psel, penable, pwrite} = 4'h0;
      paddr = 8'h0;
      pwdata = 32'h0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      t_regs;
      t_wr;
      t_stat;
      t_bad;
      t_modem;
      report_and_stop;
   end
endmodule
bind twc_host twc_host_props u_props (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .paddr(paddr), .pready(pready),
   .pslverr(pslverr), .sclk(sclk), .en(en), .data_o(data_o),
   .data_oe(data_oe));
`default_nettype wire
